// *** include/sram_front_pkg.sv ***
// Purpose: shared constants and types for the burst sram control front end
// Assumes: one 20 MHz clock, asynchronous active-low reset
// Notes:   the data word is four byte lanes of nine bits each

`default_nettype none

package sram_front_pkg;

    // clock figures
    localparam int CLK_PERIOD_NS = 50;

    // address and data geometry
    localparam int ADDR_W      = 18;
    localparam int LANES       = 4;
    localparam int LANE_W      = 9;
    localparam int DATA_W      = LANES * LANE_W;
    localparam int BURST_W     = 2;
    localparam int UPPER_W     = ADDR_W - BURST_W;

    // write buffer geometry
    localparam int FIFO_DEPTH  = 16;
    localparam int WR_WORD_W   = ADDR_W + LANES + DATA_W;

    // field positions inside a buffered write word
    localparam int WR_DATA_LSB = 0;
    localparam int WR_LANE_LSB = DATA_W;
    localparam int WR_ADDR_LSB = DATA_W + LANES;

    // reset values and lane masks
    localparam logic [1:0]         BURST_CNT_RST = 2'h0;
    localparam logic [ADDR_W-1:0]  ADDR_RST      = 18'h00000;
    localparam logic [LANES-1:0]   ALL_LANES     = 4'hF;
    localparam logic [LANES-1:0]   NO_LANES      = 4'h0;

    // kind of cycle in progress after a clock edge
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_READ,
        CYC_WRITE
    } cyc_t;

endpackage

`default_nettype wire

// *** hw/word_fifo.sv ***
// Purpose: small first-in first-out buffer with registered read data
// Assumes: depth is a power of two; one clock, asynchronous active-low reset
// Notes:   holds depth words plus one in the output register

`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
    parameter int WIDTH = sram_front_pkg::WR_WORD_W,
    parameter int DEPTH = sram_front_pkg::FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
        logic                        out_valid;
        logic [WIDTH-1:0]            out_data;
    } fifo_state_t;

    fifo_state_t s_ff;
    fifo_state_t nxt_s;
    logic        push;
    logic        pop;

    // handshake outputs straight from state
    assign in_ready  = (s_ff.count != FULL_COUNT);
    assign out_valid = s_ff.out_valid;
    assign out_data  = s_ff.out_data;

    // next state: refill the output register whenever it is free or drained
    always_comb begin
        nxt_s = s_ff;
        push  = in_valid && in_ready;
        pop   = (s_ff.count != '0) && (!s_ff.out_valid || out_ready);
        if (s_ff.out_valid && out_ready) begin
            nxt_s.out_valid = 1'b0;
        end
        if (pop) begin
            nxt_s.out_data  = s_ff.mem[s_ff.rd_ptr];
            nxt_s.out_valid = 1'b1;
            nxt_s.rd_ptr    = PW'(s_ff.rd_ptr + 1'b1);
        end
        if (push) begin
            nxt_s.mem[s_ff.wr_ptr] = in_data;
            nxt_s.wr_ptr           = PW'(s_ff.wr_ptr + 1'b1);
        end
        if (push && !pop) begin
            nxt_s.count = (PW + 1)'(s_ff.count + 1'b1);
        end else if (pop && !push) begin
            nxt_s.count = (PW + 1)'(s_ff.count - 1'b1);
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule

`default_nettype wire

// *** hw/sync_burst_sram_control.sv ***
// Purpose: control front end of a synchronous flow-through burst sram
// Assumes: the bus master runs on sys_clk; the array has separate read and write ports
// Notes:   writes queue in a buffer and reach the array self-timed

`timescale 1ns/1ps
`default_nettype none

module sync_burst_sram_control #(
    parameter bit HAS_DEPTH_SEL = 1'b1,
    parameter int FIFO_DEPTH    = sram_front_pkg::FIFO_DEPTH
) (
    input  wire logic                                 sys_clk,
    input  wire logic                                 rstn,
    // address pins
    input  wire logic [sram_front_pkg::UPPER_W-1:0]   addr_upper,
    input  wire logic                                 addr_bit_one,
    input  wire logic                                 addr_bit_zero,
    // select and strobe pins
    input  wire logic                                 chip_select_n,
    input  wire logic                                 chip_select_high,
    input  wire logic                                 depth_select_low_n,
    input  wire logic                                 processor_addr_strobe_n,
    input  wire logic                                 controller_addr_strobe_n,
    input  wire logic                                 burst_step_n,
    // write control pins
    input  wire logic                                 lane_write_1_n,
    input  wire logic                                 lane_write_2_n,
    input  wire logic                                 lane_write_3_n,
    input  wire logic                                 lane_write_4_n,
    input  wire logic                                 byte_write_gate_n,
    input  wire logic                                 global_write_n,
    // asynchronous and static pins
    input  wire logic                                 output_enable_n,
    input  wire logic                                 burst_mode,
    input  wire logic                                 sleep_request,
    // two-way data pins, one lane each
    input  wire logic [sram_front_pkg::LANE_W-1:0]    data_byte_lane_1_in,
    output logic      [sram_front_pkg::LANE_W-1:0]    data_byte_lane_1_out,
    output logic      [sram_front_pkg::LANE_W-1:0]    data_byte_lane_1_oe,
    input  wire logic [sram_front_pkg::LANE_W-1:0]    data_byte_lane_2_in,
    output logic      [sram_front_pkg::LANE_W-1:0]    data_byte_lane_2_out,
    output logic      [sram_front_pkg::LANE_W-1:0]    data_byte_lane_2_oe,
    input  wire logic [sram_front_pkg::LANE_W-1:0]    data_byte_lane_3_in,
    output logic      [sram_front_pkg::LANE_W-1:0]    data_byte_lane_3_out,
    output logic      [sram_front_pkg::LANE_W-1:0]    data_byte_lane_3_oe,
    input  wire logic [sram_front_pkg::LANE_W-1:0]    data_byte_lane_4_in,
    output logic      [sram_front_pkg::LANE_W-1:0]    data_byte_lane_4_out,
    output logic      [sram_front_pkg::LANE_W-1:0]    data_byte_lane_4_oe,
    // array read port
    output logic                                      arr_rd_en,
    output logic      [sram_front_pkg::ADDR_W-1:0]    arr_rd_addr,
    input  wire logic [sram_front_pkg::DATA_W-1:0]    arr_rd_data,
    // array write port
    output logic                                      arr_wr_valid,
    input  wire logic                                 arr_wr_ready,
    output logic      [sram_front_pkg::ADDR_W-1:0]    arr_wr_addr,
    output logic      [sram_front_pkg::LANES-1:0]     arr_wr_lanes,
    output logic      [sram_front_pkg::DATA_W-1:0]    arr_wr_data,
    // status
    output logic                                      write_ready,
    output logic                                      selected,
    output logic                                      standby
);

    localparam int ADDR_W  = sram_front_pkg::ADDR_W;
    localparam int UPPER_W = sram_front_pkg::UPPER_W;
    localparam int LANE_W  = sram_front_pkg::LANE_W;
    localparam int LANES   = sram_front_pkg::LANES;
    localparam int DATA_W  = sram_front_pkg::DATA_W;
    localparam int WW      = sram_front_pkg::WR_WORD_W;

    // whole state of the front end apart from the write buffer
    typedef struct packed {
        logic [1:0]         sleep_sync;
        logic [1:0]         mode_sync;
        logic [ADDR_W-1:0]  addr;
        logic [1:0]         count;
        logic               selected;
        sram_front_pkg::cyc_t cyc;
    } front_state_t;

    front_state_t s_ff;
    front_state_t nxt_s;

    // combinational helpers
    logic              sel_now;
    logic              proc_start;
    logic              ctrl_start;
    logic              sleeping;
    logic              linear;
    logic [LANES-1:0]  lane_req;
    logic [LANES-1:0]  wr_lanes;
    logic              wr_req;
    logic              wr_pins_active;
    logic [ADDR_W-1:0] ext_addr;
    logic [ADDR_W-1:0] nxt_eff_addr;
    logic [ADDR_W-1:0] cur_eff_addr;
    logic [DATA_W-1:0] data_in;
    logic              drive_en;
    logic              push_valid;
    logic              push_ready;
    logic [WW-1:0]     push_word;
    logic              pop_valid;
    logic [WW-1:0]     pop_word;

    // low two address bits of a burst beat
    function automatic logic [1:0] burst_low(
        input logic [1:0] base,
        input logic [1:0] cnt,
        input logic       lin
    );
        logic [1:0] res;
        if (lin) begin
            res = 2'(base + cnt);
        end else begin
            res = base ^ cnt;
        end
        return res;
    endfunction

    // full word address of a burst beat
    function automatic logic [ADDR_W-1:0] beat_addr(
        input logic [ADDR_W-1:0] base,
        input logic [1:0]        cnt,
        input logic              lin
    );
        return {base[ADDR_W-1:2], burst_low(base[1:0], cnt, lin)};
    endfunction

    // pin groups gathered into words
    assign ext_addr = {addr_upper, addr_bit_one, addr_bit_zero};
    assign data_in  = {data_byte_lane_4_in, data_byte_lane_3_in,
                       data_byte_lane_2_in, data_byte_lane_1_in};

    // lane requests, low means write that lane
    assign lane_req = ~{lane_write_4_n, lane_write_3_n,
                        lane_write_2_n, lane_write_1_n};

    // enable decode from the three selects
    assign sel_now = !chip_select_n
                   && chip_select_high
                   && (!HAS_DEPTH_SEL || !depth_select_low_n);

    // strobes; the processor strobe is dead while the primary select is high
    assign proc_start = !processor_addr_strobe_n && !chip_select_n;
    assign ctrl_start = !controller_addr_strobe_n;

    // synchronised static and asynchronous levels
    assign sleeping = s_ff.sleep_sync[1];
    assign linear   = !s_ff.mode_sync[1];

    // lane selection: global write overrides, byte lanes need the gate
    always_comb begin
        if (!global_write_n) begin
            wr_lanes = sram_front_pkg::ALL_LANES;
        end else if (!byte_write_gate_n) begin
            wr_lanes = lane_req;
        end else begin
            wr_lanes = sram_front_pkg::NO_LANES;
        end
    end
    assign wr_req = (wr_lanes != sram_front_pkg::NO_LANES);

    // pins ask for a write right now, so the drivers must let go at once
    assign wr_pins_active = !global_write_n
                          || (!byte_write_gate_n && (lane_req != '0));

    // next state of the cycle engine, strobe, select, address and write pins taken on the same edge
    always_comb begin
        nxt_s            = s_ff;
        nxt_s.sleep_sync = {s_ff.sleep_sync[0], sleep_request};
        nxt_s.mode_sync  = {s_ff.mode_sync[0], burst_mode};
        if (sleeping) begin
            // standby ends any burst; a new strobe is needed after wake-up
            nxt_s.selected = 1'b0;
            nxt_s.cyc      = sram_front_pkg::CYC_IDLE;
        end else if (proc_start) begin
            // processor strobe wins over the controller strobe
            nxt_s.addr     = ext_addr;
            nxt_s.count    = sram_front_pkg::BURST_CNT_RST;
            nxt_s.selected = sel_now;
            nxt_s.cyc      = sel_now ? sram_front_pkg::CYC_READ
                                     : sram_front_pkg::CYC_IDLE;
        end else if (ctrl_start) begin
            nxt_s.addr     = ext_addr;
            nxt_s.count    = sram_front_pkg::BURST_CNT_RST;
            nxt_s.selected = sel_now;
            if (!sel_now) begin
                nxt_s.cyc = sram_front_pkg::CYC_IDLE;
            end else if (wr_req) begin
                nxt_s.cyc = sram_front_pkg::CYC_WRITE;
            end else begin
                nxt_s.cyc = sram_front_pkg::CYC_READ;
            end
        end else if (s_ff.selected) begin
            // burst continuation or wait cycle
            if (!burst_step_n) begin
                nxt_s.count = 2'(s_ff.count + 1'b1);
            end
            nxt_s.cyc = wr_req ? sram_front_pkg::CYC_WRITE
                               : sram_front_pkg::CYC_READ;
        end else begin
            nxt_s.cyc = sram_front_pkg::CYC_IDLE;
        end
    end

    // effective addresses of the coming and the current beat
    assign nxt_eff_addr = beat_addr(nxt_s.addr, nxt_s.count, linear);
    assign cur_eff_addr = beat_addr(s_ff.addr, s_ff.count, linear);

    // write word enters the buffer on the same edge that registers the pins
    assign push_valid = (nxt_s.cyc == sram_front_pkg::CYC_WRITE);
    assign push_word  = {nxt_eff_addr, wr_lanes, data_in};

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // write buffer; the array drains it at its own pace
    word_fifo #(
        .WIDTH (WW),
        .DEPTH (FIFO_DEPTH)
    ) u_write_buffer (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (pop_valid),
        .out_ready (arr_wr_ready),
        .out_data  (pop_word)
    );

    // self-timed completion toward the array
    assign arr_wr_valid = pop_valid;
    assign arr_wr_addr  = pop_word[sram_front_pkg::WR_ADDR_LSB +: ADDR_W];
    assign arr_wr_lanes = pop_word[sram_front_pkg::WR_LANE_LSB +: LANES];
    assign arr_wr_data  = pop_word[sram_front_pkg::WR_DATA_LSB +: DATA_W];
    assign write_ready  = push_ready;

    // flow-through read: array data goes to the pins with no output stage
    assign arr_rd_en   = (s_ff.cyc == sram_front_pkg::CYC_READ);
    assign arr_rd_addr = cur_eff_addr;

    // output drivers: async enable gates them, never during writes or sleep
    assign drive_en = !output_enable_n
                    && arr_rd_en
                    && !wr_pins_active
                    && !sleeping;

    // lane outputs; enable kept per bit so every pin has its own enable
    assign data_byte_lane_1_out = arr_rd_data[0*LANE_W +: LANE_W];
    assign data_byte_lane_2_out = arr_rd_data[1*LANE_W +: LANE_W];
    assign data_byte_lane_3_out = arr_rd_data[2*LANE_W +: LANE_W];
    assign data_byte_lane_4_out = arr_rd_data[3*LANE_W +: LANE_W];
    assign data_byte_lane_1_oe  = {LANE_W{drive_en}};
    assign data_byte_lane_2_oe  = {LANE_W{drive_en}};
    assign data_byte_lane_3_oe  = {LANE_W{drive_en}};
    assign data_byte_lane_4_oe  = {LANE_W{drive_en}};

    // status from state
    assign selected = s_ff.selected;
    assign standby  = sleeping;

endmodule

`default_nettype wire

// *** testbench/sram_front_sva.sv ***
// Purpose: pin-level checks on the burst sram control front end
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   watches top-level ports only, attached by bind below

`timescale 1ns/1ps
`default_nettype none

module sram_front_sva (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [15:0] addr_upper,
    input wire logic        addr_bit_one,
    input wire logic        addr_bit_zero,
    input wire logic        chip_select_n,
    input wire logic        chip_select_high,
    input wire logic        depth_select_low_n,
    input wire logic        processor_addr_strobe_n,
    input wire logic        controller_addr_strobe_n,
    input wire logic        burst_step_n,
    input wire logic        lane_write_1_n,
    input wire logic        lane_write_2_n,
    input wire logic        lane_write_3_n,
    input wire logic        lane_write_4_n,
    input wire logic        byte_write_gate_n,
    input wire logic        global_write_n,
    input wire logic        output_enable_n,
    input wire logic [8:0]  data_byte_lane_1_out,
    input wire logic [8:0]  data_byte_lane_4_out,
    input wire logic [8:0]  data_byte_lane_1_oe,
    input wire logic        arr_rd_en,
    input wire logic [17:0] arr_rd_addr,
    input wire logic [35:0] arr_rd_data,
    input wire logic        arr_wr_valid,
    input wire logic        arr_wr_ready,
    input wire logic [17:0] arr_wr_addr,
    input wire logic [35:0] arr_wr_data,
    input wire logic        selected,
    input wire logic        standby
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // strobe and select relations, all registered on one edge
    a_proc_read: assert property (
        !processor_addr_strobe_n && !chip_select_n && chip_select_high && !depth_select_low_n
        && !standby |=> arr_rd_en && arr_rd_addr == $past({addr_upper, addr_bit_one, addr_bit_zero}))
        else $error("processor strobe did not start a read at the pin address");
    a_proc_gated: assert property (
        !processor_addr_strobe_n && chip_select_n && controller_addr_strobe_n && !selected
        |=> !selected && !arr_rd_en) else $error("processor strobe taken while unselected");
    a_ctrl_deselect: assert property (
        !controller_addr_strobe_n && processor_addr_strobe_n
        && (chip_select_n || !chip_select_high || depth_select_low_n) |=> !selected)
        else $error("controller strobe with a select off did not deselect");
    // driver enables: async enable, write pins and sleep all win
    a_oe_enable: assert property (
        data_byte_lane_1_oe[0] |-> !output_enable_n && arr_rd_en && !standby)
        else $error("data pins driven without enable or read");
    a_lane_wr_off: assert property (
        !byte_write_gate_n && !(lane_write_1_n && lane_write_2_n && lane_write_3_n
        && lane_write_4_n) |-> data_byte_lane_1_oe == 9'h000) else $error("pins driven in write");
    a_flow_through: assert property (
        arr_rd_en |-> data_byte_lane_1_out == arr_rd_data[8:0]
        && data_byte_lane_4_out == arr_rd_data[35:27]) else $error("read data not flow-through");
    a_burst_wait: assert property (
        arr_rd_en && processor_addr_strobe_n && controller_addr_strobe_n && burst_step_n
        && global_write_n && byte_write_gate_n && !standby |=> arr_rd_en && $stable(arr_rd_addr))
        else $error("wait cycle moved the burst address");
    a_wr_word_hold: assert property (
        arr_wr_valid && !arr_wr_ready |=> arr_wr_valid && $stable(arr_wr_addr)
        && $stable(arr_wr_data)) else $error("write word changed while stalled");
    a_sleep_idle: assert property (
        standby && $past(standby) |-> !selected && !arr_rd_en) else $error("active in standby");
endmodule

bind sync_burst_sram_control sram_front_sva u_sva (.*);

`default_nettype wire

// *** testbench/array_model.sv ***
// Purpose: behavioural array behind the read and write ports
// Assumes: read data follows the read address combinationally
// Notes:   stall holds off writes; idle reads show a flipping pattern

`timescale 1ns/1ps
`default_nettype none

module array_model (
    input  wire logic        sys_clk,
    input  wire logic        stall,
    input  wire logic        arr_rd_en,
    input  wire logic [17:0] arr_rd_addr,
    output logic      [35:0] arr_rd_data,
    input  wire logic        arr_wr_valid,
    output logic             arr_wr_ready,
    input  wire logic [17:0] arr_wr_addr,
    input  wire logic [3:0]  arr_wr_lanes,
    input  wire logic [35:0] arr_wr_data
);
    logic [35:0] mem [logic [17:0]];
    logic        tog = 1'b0;

    // unknown words must not look like a match, so they flip each cycle
    function automatic logic [35:0] fetch(logic en, logic [17:0] a, logic t);
        if (en && mem.exists(a))
            return mem[a];
        return {18{t, ~t}};
    endfunction

    assign arr_rd_data  = fetch(arr_rd_en, arr_rd_addr, tog);
    assign arr_wr_ready = !stall;

    // lane l holds bits 9l+8..9l; word lands once handed over
    always @(posedge sys_clk) begin
        tog <= ~tog;
        if (arr_wr_valid && arr_wr_ready) begin
            if (!mem.exists(arr_wr_addr))
                mem[arr_wr_addr] = 36'h000000000;
            for (int l = 0; l < 4; l++)
                if (arr_wr_lanes[l])
                    mem[arr_wr_addr][9*l +: 9] = arr_wr_data[9*l +: 9];
        end
    end
endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the burst sram control front end
// Assumes: pins change 5 ns after each rising edge
// Notes:   one task per scenario; array model sits on the far side

`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [4:0] IDLE = 5'h1F, PRD = 5'h0F, CRD = 5'h17, CGW = 5'h15;
    localparam logic [4:0] CBW = 5'h16, STEP = 5'h1B, WGW = 5'h1D;
    localparam int FULL = sram_front_pkg::FIFO_DEPTH + 1;
    logic sys_clk, rstn, chip_select_n, chip_select_high, depth_select_low_n, stall;
    logic processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n, global_write_n;
    logic lane_write_1_n, lane_write_2_n, lane_write_3_n, lane_write_4_n, byte_write_gate_n;
    logic output_enable_n, burst_mode, sleep_request, addr_bit_one, addr_bit_zero;
    logic [15:0] addr_upper;
    logic [35:0] din;
    wire logic [8:0] data_byte_lane_1_in, data_byte_lane_2_in, data_byte_lane_3_in;
    wire logic [8:0] data_byte_lane_4_in, data_byte_lane_1_out, data_byte_lane_2_out;
    wire logic [8:0] data_byte_lane_3_out, data_byte_lane_4_out, data_byte_lane_1_oe;
    wire logic [8:0] data_byte_lane_2_oe, data_byte_lane_3_oe, data_byte_lane_4_oe;
    wire logic arr_rd_en, arr_wr_valid, arr_wr_ready, write_ready, selected, standby;
    wire logic [17:0] arr_rd_addr, arr_wr_addr;
    wire logic [35:0] arr_rd_data, arr_wr_data, dout, oe_all;
    wire logic [3:0] arr_wr_lanes;
    int failures = 0;
    int n_checks = 0;

    // pin level: the design wins where it enables, else the bench data
    assign dout = {data_byte_lane_4_out, data_byte_lane_3_out, data_byte_lane_2_out,
                   data_byte_lane_1_out};
    assign oe_all = {data_byte_lane_4_oe, data_byte_lane_3_oe, data_byte_lane_2_oe,
                     data_byte_lane_1_oe};
    assign {data_byte_lane_4_in, data_byte_lane_3_in, data_byte_lane_2_in,
            data_byte_lane_1_in} = (oe_all & dout) | (~oe_all & din);

    sync_burst_sram_control u_dut (.*);
    array_model u_mem (.*);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ctl is {proc strobe, ctrl strobe, step, global, gate}, all active low
    task automatic drive(input logic [4:0] ctl, input logic [3:0] ln, input logic [17:0] a,
                         input logic [35:0] d);
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n, global_write_n,
         byte_write_gate_n} = ctl;
        {lane_write_4_n, lane_write_3_n, lane_write_2_n, lane_write_1_n} = ln;
        {addr_upper, addr_bit_one, addr_bit_zero} = a;
        din = d;
        @(posedge sys_clk);
        #5;
    endtask

    task automatic idle(input int n);
        repeat (n) drive(IDLE, 4'hF, 18'h00000, 36'h000000000);
    endtask

    // global write lands whole, then reads back two cycles after the write strobe
    task automatic write_read(input logic [17:0] a, input logic [35:0] d);
        drive(CGW, 4'hF, a, d);
        chk({selected, arr_rd_en}, 2'h2);
        idle(1);
        chk({arr_wr_valid, arr_wr_lanes, arr_wr_addr}, {1'b1, 4'hF, a});
        chk(arr_wr_data, d);
        drive(PRD, 4'hF, a, 36'h000000000);
        chk({arr_rd_addr, dout}, {a, d});
        chk(oe_all, 36'hFFFFFFFFF);
        output_enable_n = 1'b1;
        idle(1);
        chk({arr_rd_en, oe_all}, {1'b1, 36'h000000000});
        output_enable_n = 1'b0;
    endtask

    // one lane through the gate, then lanes without the gate are a read
    task automatic byte_lanes(input logic [17:0] a);
        logic [35:0] d0 = 36'h123456789;
        logic [35:0] d1 = 36'hFEDCBA987;
        write_read(a, d0);
        drive(CBW, 4'hD, a, d1);
        chk(oe_all, 36'h000000000);
        idle(1);
        chk(arr_wr_lanes, 4'h2);
        drive(CRD, 4'h0, a, 36'h000000000);
        chk(arr_rd_en, 1'b1);
        chk(oe_all, 36'hFFFFFFFFF);
        chk(dout, {d0[35:18], d1[17:9], d0[8:0]});
    endtask

    // steps and waits; address pins scrambled to prove the counter is used
    task automatic burst(input logic mode, input logic [17:0] a);
        logic [1:0] want;
        burst_mode = mode;
        idle(2);
        drive(PRD, 4'hF, a, 36'h000000000);
        for (int k = 1; k < 4; k++) begin
            want = mode ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
            drive(STEP, 4'hF, ~a, 36'h000000000);
            chk(arr_rd_addr, {a[17:2], want});
            drive(IDLE, 4'hF, ~a, 36'h000000000);
            chk(arr_rd_addr, {a[17:2], want});
        end
    endtask

    // each select turned off in turn: strobes must not select
    task automatic selects;
        logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
        for (int k = 0; k < 3; k++) begin
            drive(PRD, 4'hF, 18'h00100, 36'h000000000);
            chk(selected, 1'b1);
            {chip_select_n, chip_select_high, depth_select_low_n} = bad[k];
            drive(CRD, 4'hF, 18'h00104, 36'h000000000);
            chk({selected, arr_rd_en}, 2'h0);
            drive(PRD, 4'hF, 18'h00104, 36'h000000000);
            chk({selected, arr_rd_en}, 2'h0);
            {chip_select_n, chip_select_high, depth_select_low_n} = 3'h2;
        end
    endtask

    task automatic sleep_check;
        drive(PRD, 4'hF, 18'h00200, 36'h000000000);
        sleep_request = 1'b1;
        idle(3);
        chk({standby, selected, arr_rd_en, oe_all}, {3'h4, 36'h000000000});
        drive(PRD, 4'hF, 18'h00200, 36'h000000000);
        chk(arr_rd_en, 1'b0);
        sleep_request = 1'b0;
        idle(3);
        chk(standby, 1'b0);
    endtask

    // fill with the array stalled, then drain while it stalls every other cycle
    task automatic fill_drain;
        int n = 1;
        int got = 0;
        stall = 1'b1;
        drive(CGW, 4'hF, 18'h00300, 36'h000000000);
        for (int i = 1; i < 40 && write_ready; i++) begin
            drive(WGW, 4'hF, 18'h00300, 36'(i));
            n++;
        end
        chk(n, FULL);
        for (int j = 0; j < 80 && got < FULL; j++) begin
            stall = j[0];
            if (arr_wr_valid && !stall) begin
                chk({arr_wr_addr, arr_wr_data}, {18'h00300, 36'(got)});
                got++;
            end
            idle(1);
        end
        chk({got, write_ready}, {FULL, 1'b1});
        stall = 1'b0;
    endtask

    initial begin
        #2000000;
        failures++;
        wrap_up;
    end

    initial begin
        {rstn, stall, burst_mode, sleep_request, output_enable_n} = 5'h00;
        {chip_select_n, chip_select_high, depth_select_low_n} = 3'h2;
        idle(2);
        rstn = 1'b1;
        idle(1);
        write_read(18'h00040, 36'hA5A5A5A5A);
        byte_lanes(18'h00080);
        burst(1'b0, 18'h00122);
        burst(1'b1, 18'h00141);
        selects;
        sleep_check;
        fill_drain;
        wrap_up;
    end
endmodule

`default_nettype wire
